// File: core/ssg_regs.sv
// Status, alias decoder and output-pin register slice with AXI4-Lite access
//
// Behaviour
// RULE1 - Matching alias rewritten to target, then forwarded
// RULE2 - Zero alias forwards nothing
// RULE3 - Rewritten address comes from target register
// RULE4 - Count back-channel errors, 16 bits, two bytes
// RULE5 - Flag errors seen during self-test
// RULE6 - Report valid pixel clock
// RULE7 - Far-end error flag, cleared by link loss/control
// RULE8 - Report cable link present
// RULE9 - Active local pin drives local level
// RULE10 - Far control drives remote level instead
// RULE11 - Per-pin enable, off floats, reset on
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module ssg_regs #(
  parameter int          ADDR_W  = 8,    // Bus address width
  parameter int          PINS    = 2,    // Output pins in this slice
  parameter logic [2:0]  REV_ID  = 3'h5  // Arbitrary revision value
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Local I2C address to decode
  input  wire logic              local_addr_valid,
  input  wire logic [6:0]        local_addr,
  // Forward request toward the back channel
  output logic                   fwd_valid,
  output logic [6:0]             fwd_addr,
  // Link state inputs
  input  wire logic              link_detect,
  input  wire logic              pclk_detect,
  input  wire logic              rx_lock,
  input  wire logic              selftest_active,
  input  wire logic              bc_crc_error,
  input  wire logic              far_crc_error,
  // Output pins
  input  wire logic [PINS-1:0]   far_level,
  output logic [PINS-1:0]        pin_o,
  output logic [PINS-1:0]        pin_oe,
  // Interrupt
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic rst_meta_r; // First stage, read only by second
  logic rst_sync_n; // Released reset for the core

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word index of a byte address
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a >> 2;
    word_idx = w[7:0];
  endfunction : word_idx

  // Whether a word index names a register; the two groups are contiguous
  function automatic logic is_reg(input logic [7:0] i);
    is_reg = (i >= ssg_pkg::IDX_TARGET_PHYS && i <= ssg_pkg::IDX_PIN_CFG) ||
             (i >= ssg_pkg::IDX_IRQ_STATUS && i <= ssg_pkg::IDX_CONTROL);
  endfunction : is_reg

  localparam int EVT_W = ssg_pkg::EVT_W; // Number of event bits

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]       phys_r;      // Remote target physical address
  logic [7:0]       alias_r;     // Remote target alias
  logic [15:0]      crc_cnt_r;   // Back-channel error count
  logic             selft_r;     // Self-test error flag
  logic             farerr_r;    // Far-end error flag
  logic [7:0]       pin_cfg_r;   // Output pin configuration
  logic [EVT_W-1:0] irq_stat_r;  // Sticky events
  logic [EVT_W-1:0] irq_en_r;    // Event enables
  logic [7:0]       ctl_r;       // Control bits
  logic             link_r;      // Link state one cycle ago
  logic             selft_act_r; // Self-test state one cycle ago
  logic             fwd_valid_r; // Registered forward strobe
  logic [6:0]       fwd_addr_r;  // Registered forward address

  ////////////////////////////////////////////////////////////////////////////
  // Write channel state
  logic              aw_held_r; // Write address captured
  logic              w_held_r;  // Write data captured
  logic [ADDR_W-1:0] aw_addr_r; // Captured address
  logic [7:0]        w_data_r;  // Captured low data byte
  logic              w_strb_r;  // Captured low byte enable
  logic              bvalid_r;  // Response pending
  logic [1:0]        bresp_r;   // Response code

  // Handshakes and write decode
  wire logic       aw_hs;   // Address taken
  wire logic       w_hs;    // Data taken
  wire logic       wr_go;   // Both halves present, perform write
  wire logic [7:0] wr_idx;  // Target word
  wire logic       wr_byte; // Low byte is written
  wire logic       wr_hit;  // Address maps to a register

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx  = word_idx(aw_addr_r);
  assign wr_byte = wr_go && w_strb_r;
  assign wr_hit  = is_reg(wr_idx);

  // Per-register write strobes
  wire logic wr_phys;  // Target address write
  wire logic wr_alias; // Alias write
  wire logic wr_pin;   // Pin configuration write
  wire logic wr_ien;   // Enable write
  wire logic wr_iclr;  // Clear write
  wire logic wr_ctl;   // Control write

  assign wr_phys  = wr_byte && (wr_idx == ssg_pkg::IDX_TARGET_PHYS);
  assign wr_alias = wr_byte && (wr_idx == ssg_pkg::IDX_TARGET_ALIAS);
  assign wr_pin   = wr_byte && (wr_idx == ssg_pkg::IDX_PIN_CFG);
  assign wr_ien   = wr_byte && (wr_idx == ssg_pkg::IDX_IRQ_ENABLE);
  assign wr_iclr  = wr_byte && (wr_idx == ssg_pkg::IDX_IRQ_CLEAR);
  assign wr_ctl   = wr_byte && (wr_idx == ssg_pkg::IDX_CONTROL);

  // Capture the two write halves in either order, answer after both
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ssg_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_DECERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire logic [7:0] rd_idx;    // Target word
  wire logic [7:0] health;    // Assembled status byte
  logic [7:0]      rd_byte;   // Selected register value
  logic            rd_hit;    // Address maps to a register
  logic            rvalid_r;  // Read data pending
  logic [31:0]     rdata_r;   // Read data
  logic [1:0]      rresp_r;   // Read response
  wire logic       ar_hs;     // Read address taken

  assign rd_idx = word_idx(s_axi_araddr);
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_r;

  // Status byte straight from live inputs and flags
  assign health = {REV_ID,
                   rx_lock,
                   selft_r,     // [RULE5]
                   pclk_detect, // [RULE6]
                   farerr_r,    // [RULE7]
                   link_detect  // [RULE8]
                  };

  // Read selection; reserved and write-only bits read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      ssg_pkg::IDX_TARGET_PHYS:  rd_byte = {phys_r[7:1], 1'b0};
      ssg_pkg::IDX_TARGET_ALIAS: rd_byte = {alias_r[7:1], 1'b0};
      ssg_pkg::IDX_CRC_LOW:      rd_byte = crc_cnt_r[7:0];  // [RULE4]
      ssg_pkg::IDX_CRC_HIGH:     rd_byte = crc_cnt_r[15:8]; // [RULE4]
      ssg_pkg::IDX_HEALTH:       rd_byte = health;
      ssg_pkg::IDX_PIN_CFG:      rd_byte = pin_cfg_r;
      ssg_pkg::IDX_IRQ_STATUS:   rd_byte = {4'h0, irq_stat_r};
      ssg_pkg::IDX_IRQ_ENABLE:   rd_byte = {4'h0, irq_en_r};
      ssg_pkg::IDX_IRQ_CLEAR:    rd_byte = 8'h00;
      ssg_pkg::IDX_CONTROL:      rd_byte = ctl_r;
      default:                   rd_hit  = 1'b0;
    endcase
  end

  // One-cycle read answer, held until taken
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ssg_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_hit ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phys_r    <= ssg_pkg::RST_TARGET;
      alias_r   <= ssg_pkg::RST_TARGET;
      pin_cfg_r <= ssg_pkg::RST_PIN_CFG; // [RULE11]
      irq_en_r  <= '0;
      ctl_r     <= ssg_pkg::RST_ZERO;
    end else begin
      if (wr_phys) begin
        phys_r <= w_data_r; // [RULE3]
      end
      if (wr_alias) begin
        alias_r <= w_data_r;
      end
      if (wr_pin) begin
        pin_cfg_r <= w_data_r & ssg_pkg::PIN_CFG_MASK;
      end
      if (wr_ien) begin
        irq_en_r <= w_data_r[EVT_W-1:0];
      end
      if (wr_ctl) begin
        ctl_r <= {7'h00, w_data_r[ssg_pkg::CTL_ERR_RST]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alias decoder
  wire logic alias_on;  // Nonzero alias enables forwarding
  wire logic alias_hit; // Local address matches alias

  assign alias_on  = (alias_r[7:1] != 7'h00); // [RULE2]
  assign alias_hit = local_addr_valid && alias_on &&
                     (local_addr == alias_r[7:1]); // [RULE1]

  // Rewrite to the physical address and emit one-cycle forward strobe
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fwd_valid_r <= 1'b0;
      fwd_addr_r  <= 7'h00;
    end else begin
      fwd_valid_r <= alias_hit; // [RULE1]
      if (alias_hit) begin
        fwd_addr_r <= phys_r[7:1]; // [RULE3]
      end
    end
  end

  assign fwd_valid = fwd_valid_r;
  assign fwd_addr  = fwd_addr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Error counting and status flags
  wire logic normal_err; // Error outside self-test
  wire logic selft_err;  // Error during self-test
  wire logic selft_go;   // Self-test run starts
  wire logic link_lost;  // Cable link fell
  wire logic err_rst;    // Control asks for flag clear

  assign normal_err = bc_crc_error && !selftest_active;
  assign selft_err  = bc_crc_error && selftest_active;
  assign selft_go   = selftest_active && !selft_act_r;
  assign link_lost  = link_r && !link_detect;
  assign err_rst    = ctl_r[ssg_pkg::CTL_ERR_RST];

  // Counter saturates so it never wraps back to a small value
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crc_cnt_r   <= 16'h0000;
      selft_r     <= 1'b0;
      farerr_r    <= 1'b0;
      link_r      <= 1'b0;
      selft_act_r <= 1'b0;
    end else begin
      link_r      <= link_detect;
      selft_act_r <= selftest_active;
      if (normal_err && (crc_cnt_r != 16'hffff)) begin
        crc_cnt_r <= crc_cnt_r + 16'h0001; // [RULE4]
      end
      // New run starts clean; an error in that cycle still sets
      if (selft_err) begin
        selft_r <= 1'b1; // [RULE5]
      end else if (selft_go) begin
        selft_r <= 1'b0; // [RULE5]
      end
      // No link means no far-end error; control clear loses to a new error
      if (!link_detect) begin
        farerr_r <= 1'b0; // [RULE7]
      end else if (far_crc_error) begin
        farerr_r <= 1'b1; // [RULE7]
      end else if (err_rst) begin
        farerr_r <= 1'b0; // [RULE7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  wire logic [EVT_W-1:0] evt;     // Events this cycle
  wire logic [EVT_W-1:0] clr_msk; // Bits software clears

  assign evt = {link_lost, selft_err, far_crc_error && link_detect,
                normal_err};
  assign clr_msk = wr_iclr ? w_data_r[EVT_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr_msk) | evt;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Output pin drivers
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    ssg_pin_drv u_pin (
      .clk         (sys_clk),
      .rst_n       (rst_sync_n),
      .active      (pin_cfg_r[ssg_pkg::PIN_ACTIVE + p*ssg_pkg::PIN_STRIDE]),
      .far_control (pin_cfg_r[ssg_pkg::PIN_FAR + p*ssg_pkg::PIN_STRIDE]),
      .local_level (pin_cfg_r[ssg_pkg::PIN_LEVEL + p*ssg_pkg::PIN_STRIDE]),
      .far_level   (far_level[p]),
      .pin_o       (pin_o[p]),
      .pin_oe      (pin_oe[p])
    );
  end

endmodule : ssg_regs

// File: core/ssg_pkg.sv
// Constants shared by the serializer status and output-pin register slice
package ssg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TARGET_PHYS  = 8'h08; // Remote target address
  localparam logic [7:0] IDX_TARGET_ALIAS = 8'h09; // Remote target alias
  localparam logic [7:0] IDX_CRC_LOW      = 8'h0a; // Error count low byte
  localparam logic [7:0] IDX_CRC_HIGH     = 8'h0b; // Error count high byte
  localparam logic [7:0] IDX_HEALTH       = 8'h0c; // Link health flags
  localparam logic [7:0] IDX_PIN_CFG      = 8'h0d; // Output pin config
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h10; // Sticky event bits
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h11; // Event enables
  localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h12; // Write one to clear
  localparam logic [7:0] IDX_CONTROL      = 8'h13; // Block control

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_TARGET = 8'h00; // Alias and address
  localparam logic [7:0] RST_PIN_CFG = 8'h55; // Both pins on, far control
  localparam logic [7:0] RST_ZERO    = 8'h00; // Everything else

  ////////////////////////////////////////////////////////////////////////////
  // Health flag positions
  localparam int HLT_LINK   = 0; // Cable link present
  localparam int HLT_FARERR = 1; // Far-end error flag
  localparam int HLT_PCLK   = 2; // Pixel clock valid
  localparam int HLT_SELFT  = 3; // Self-test error flag
  localparam int HLT_LOCK   = 4; // Receiver locked
  localparam int HLT_REV    = 5; // Revision field, bits 7:5

  ////////////////////////////////////////////////////////////////////////////
  // Pin configuration positions, pin n at base plus four times n
  localparam int PIN_ACTIVE = 0; // Pin function enabled
  localparam int PIN_FAR    = 2; // Remote control enabled
  localparam int PIN_LEVEL  = 3; // Local output level
  localparam int PIN_STRIDE = 4; // Bits between pins
  localparam logic [7:0] PIN_CFG_MASK = 8'hdd; // Writable, non-reserved

  ////////////////////////////////////////////////////////////////////////////
  // Event bits and control bits
  localparam int EVT_BC_CRC  = 0; // Back-channel error counted
  localparam int EVT_FARERR  = 1; // Far-end error seen
  localparam int EVT_SELFT   = 2; // Error during self-test
  localparam int EVT_LINKOFF = 3; // Cable link lost
  localparam int EVT_W       = 4; // Number of event bits
  localparam int CTL_ERR_RST = 0; // Hold far-end error flag clear

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0; // Access done
  localparam logic [1:0] RESP_DECERR = 2'h3; // No register there

endpackage : ssg_pkg

// File: core/ssg_pin_drv.sv
// Driver for one general-purpose output pin
`timescale 1ns/1ps
module ssg_pin_drv (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Configuration
  input  wire logic active,
  input  wire logic far_control,
  input  wire logic local_level,
  // Level sent by the remote deserializer
  input  wire logic far_level,
  // Pin
  output logic      pin_o,
  output logic      pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Next pin state
  wire logic level_nxt; // Chosen level
  wire logic oe_nxt;    // Drive enable

  // Far control overrides the local level when set
  assign level_nxt = far_control ? far_level : local_level; // [RULE9] [RULE10]
  // Inactive pin floats; active pin is always an output here
  assign oe_nxt    = active; // [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= level_nxt & oe_nxt;
      pin_oe <= oe_nxt;
    end
  end

endmodule : ssg_pin_drv

// File: dv/ssg_regs_asserts.sv
// Concurrent checks on the ports of the register slice
`timescale 1ns/1ps
module ssg_chk #(
  parameter int ADDR_W = 8, // Bus address width
  parameter int PINS   = 2  // Output pins
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Decoder, status and pins
  input wire logic              local_addr_valid,
  input wire logic              fwd_valid,
  input wire logic              link_detect,
  input wire logic              pclk_detect,
  input wire logic [PINS-1:0]   pin_o,
  input wire logic [PINS-1:0]   pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Address of the read in flight
  logic [ADDR_W-1:0] rd_addr_r;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) rd_addr_r <= '0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  wire hlt_rd = rd_addr_r == ADDR_W'(4 * ssg_pkg::IDX_HEALTH);
  ////////////////////////////////////////////////////////////////////////////
  property p_fwd_cause;
    fwd_valid |-> $past(local_addr_valid);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause)
    else $error("forward without address");
  property p_float;
    (pin_o & ~pin_oe) == '0;
  endproperty
  a_float: assert property (p_float)
    else $error("undriven pin shows level");
  property p_health;
    $rose(s_axi_rvalid) && hlt_rd |-> s_axi_rdata[0] == $past(link_detect)
      && s_axi_rdata[2] == $past(pclk_detect);
  endproperty
  a_health: assert property (p_health)
    else $error("health flags wrong");
  property p_bv_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bv_hold: assert property (p_bv_hold)
    else $error("bvalid dropped");
  property p_rv_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rv_hold: assert property (p_rv_hold)
    else $error("read data not held");
  property p_blocked;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("write taken while bvalid");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while rvalid");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read data late");
  // Main scenarios reached
  c_fwd: cover property (fwd_valid);
  c_hlt: cover property ($rose(s_axi_rvalid) && hlt_rd);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : ssg_chk

bind ssg_regs ssg_chk #(.ADDR_W(ADDR_W), .PINS(PINS)) ssg_chk_i (.*);

// File: dv/ssg_far_end.sv
// Model of the remote deserializer: pin levels and far-end errors
`timescale 1ns/1ps
module ssg_far_end (
  // Clock
  input  wire logic       sys_clk,
  // Commands from the bench
  input  wire logic [1:0] lvl_cmd,
  input  wire logic       err_cmd,
  // Toward the slice
  output logic [1:0]      far_level,
  output logic            far_crc_error
);
  initial {far_level, far_crc_error} = 3'h0;
  // Back channel delivers one cycle after the command
  always @(posedge sys_clk) begin
    far_level <= lvl_cmd;
    far_crc_error <= err_cmd;
  end
endmodule : ssg_far_end

// File: dv/ssg_regs_tb.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
module ssg_regs_tb;
  localparam logic [2:0] REV = 3'h2; // Arbitrary revision value
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, local_addr_valid;
  logic fwd_valid, link_detect, pclk_detect, rx_lock, selftest_active;
  logic bc_crc_error, far_crc_error, err_cmd, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, far_level, pin_o, pin_oe, lvl_cmd;
  logic [6:0] local_addr, fwd_addr;
  int errors, n_tests;

  ssg_regs #(.REV_ID(REV)) ssg_regs_i (.*);
  ssg_far_end ssg_far_end_i (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One access; a write offers both channels, each held until taken
  task automatic acc(input logic we, input logic [7:0] idx, d,
                     input logic [1:0] er);
    logic a, w, b;
    logic [31:0] g;
    logic [1:0] rs;
    int k;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx[5:0], 2'h0};
    s_axi_araddr <= {idx[5:0], 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk);
      a = we ? s_axi_awready : s_axi_arready;
      w = s_axi_wready;
      b = we ? s_axi_bvalid : s_axi_rvalid;
      rs = we ? s_axi_bresp : s_axi_rresp;
      g = s_axi_rdata;
      @(posedge sys_clk);
      if (a) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (k == 40) errors++;
    if (k == 40) give_verdict();
    if (!we) chk($sformatf("reg %h", idx), {24'h0, d}, g);
    chk("resp", er, rs);
  endtask : acc
  task automatic wr(input logic [7:0] i, d,
                    input logic [1:0] r = ssg_pkg::RESP_OKAY);
    acc(1'b1, i, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] i, e,
                    input logic [1:0] r = ssg_pkg::RESP_OKAY);
    acc(1'b0, i, e, r);
  endtask : rd
  // One local address offered to the decoder
  task automatic try_alias(input logic [6:0] a, ex, input logic hit);
    @(posedge sys_clk);
    local_addr <= a;
    local_addr_valid <= 1'b1;
    @(posedge sys_clk);
    local_addr_valid <= 1'b0;
    @(negedge sys_clk);
    chk("fwd_valid", hit, fwd_valid);
    if (hit) chk("fwd_addr", ex, fwd_addr);
  endtask : try_alias
  // Pin state once levels have passed through
  task automatic pins(input logic [1:0] oe, o);
    tick(3);
    @(negedge sys_clk);
    chk("pin_oe", oe, pin_oe);
    chk("pin_o", o, pin_o);
  endtask : pins
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, local_addr_valid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    local_addr = 7'h00;
    {link_detect, pclk_detect, rx_lock} = 3'h7;
    {selftest_active, bc_crc_error, err_cmd} = 3'h0;
    lvl_cmd = 2'h1;
    tick(12);
    rst_n <= 1'b1;
    tick(3);
    // Reset values, pins under far control
    rd(ssg_pkg::IDX_TARGET_ALIAS, 8'h00);
    rd(ssg_pkg::IDX_CRC_HIGH, 8'h00);
    rd(ssg_pkg::IDX_PIN_CFG, 8'h55);
    pins(2'h3, 2'h1);
    lvl_cmd <= 2'h2;
    pins(2'h3, 2'h2);
    // Local levels, one pin floated, reserved bits
    wr(ssg_pkg::IDX_PIN_CFG, 8'h89);
    rd(ssg_pkg::IDX_PIN_CFG, 8'h89);
    pins(2'h1, 2'h1);
    wr(ssg_pkg::IDX_PIN_CFG, 8'h22);
    rd(ssg_pkg::IDX_PIN_CFG, 8'h00);
    pins(2'h0, 2'h0);
    // Alias decoder
    wr(ssg_pkg::IDX_TARGET_PHYS, 8'h66);
    wr(ssg_pkg::IDX_TARGET_ALIAS, 8'h01);
    rd(ssg_pkg::IDX_TARGET_ALIAS, 8'h00);
    try_alias(7'h00, 7'h00, 1'b0);
    wr(ssg_pkg::IDX_TARGET_ALIAS, 8'ha4);
    try_alias(7'h52, 7'h33, 1'b1);
    try_alias(7'h53, 7'h00, 1'b0);
    // Error counter and interrupt
    wr(ssg_pkg::IDX_IRQ_ENABLE, 8'h01);
    @(posedge sys_clk);
    bc_crc_error <= 1'b1;
    tick(3);
    bc_crc_error <= 1'b0;
    @(negedge sys_clk);
    chk("irq", 1'b1, irq);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h03);
    wr(ssg_pkg::IDX_CRC_LOW, 8'hff);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h03);
    rd(ssg_pkg::IDX_CRC_HIGH, 8'h00);
    wr(ssg_pkg::IDX_IRQ_CLEAR, 8'h01);
    @(negedge sys_clk);
    chk("irq", 1'b0, irq);
    // Errors during self-test
    @(posedge sys_clk);
    selftest_active <= 1'b1;
    @(posedge sys_clk);
    bc_crc_error <= 1'b1;
    @(posedge sys_clk);
    bc_crc_error <= 1'b0;
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h1d});
    rd(ssg_pkg::IDX_CRC_LOW, 8'h03);
    selftest_active <= 1'b0;
    tick(1);
    selftest_active <= 1'b1;
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h15});
    // Far-end errors, software clear, link loss
    selftest_active <= 1'b0;
    pclk_detect <= 1'b0;
    err_cmd <= 1'b1;
    tick(1);
    err_cmd <= 1'b0;
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h13});
    wr(ssg_pkg::IDX_CONTROL, 8'h01);
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h11});
    wr(ssg_pkg::IDX_CONTROL, 8'h00);
    err_cmd <= 1'b1;
    tick(1);
    err_cmd <= 1'b0;
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h13});
    link_detect <= 1'b0;
    rd(ssg_pkg::IDX_HEALTH, {REV, 5'h10});
    rd(ssg_pkg::IDX_IRQ_STATUS, 8'h0e);
    // Unmapped place
    rd(8'h3f, 8'h00, ssg_pkg::RESP_DECERR);
    wr(8'h3f, 8'h12, ssg_pkg::RESP_DECERR);
    give_verdict();
  end
endmodule : ssg_regs_tb
